// *** design/oh_regs.svh ***
// register offsets, reset values and timing counts of the overhead port
// assumes a 12-bit apb byte address with word-aligned registers
`ifndef OH_REGS_SVH
`define OH_REGS_SVH

`define OH_CTRL_ADDR   12'h000
`define OH_CHEN_ADDR   12'h004
`define OH_STAT_ADDR   12'h008

`define OH_CTRL_RST    3'h0
`define OH_CHEN_RST    16'h0000

`define OH_BIT_LAST    3'h7
`define OH_FRAME_LAST  5'h17
`define OH_REF_LAST    4'hF
`define OH_STAT_PAD    14'h0000

`endif

// *** design/oh_pkg.sv ***
// types and a helper used by the overhead port; its buffer uses none
// assumes nothing beyond a single pclk domain
`default_nettype none
package oh_pkg;

    typedef struct packed {
        logic fifo_bypass;
        logic clk_fp_en;
        logic serial_mode;
    } ctrl_t;

    typedef struct packed {
        logic [7:0] oh_en;
        logic [7:0] rx_en;
    } chen_t;

    typedef struct packed {
        logic [7:0] serial;
        logic [7:0] parallel;
    } prot_sel_t;

    // one pair select drives both channels of its pair
    function automatic logic [7:0] pair_expand(input logic [3:0] pair);
        pair_expand = {pair[3], pair[3], pair[2], pair[2],
                       pair[1], pair[1], pair[0], pair[0]};
    endfunction

endpackage
`default_nettype wire

// *** design/oh_pair_buffer.sv ***
// two-entry valid/ready buffer for assembled overhead words
// assumes both sides on pclk; outputs come from registers
`default_nettype none
module oh_pair_buffer (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // fill side
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire logic [63:0] in_data,
    // drain side
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic [63:0]      out_data
);
    logic [63:0] tail_q;
    logic [1:0]  cnt_q;
    logic [1:0]  cnt_d;
    logic        push;
    logic        pop;

    assign push  = in_valid & in_ready;
    assign pop   = out_valid & out_ready;
    assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q     <= 2'h0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            in_ready  <= (cnt_d != 2'h2);
            out_valid <= (cnt_d != 2'h0);
        end
    end

    // head is out_data, tail holds the second word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_data <= 64'h0;
            tail_q   <= 64'h0;
        end else begin
            if (pop && cnt_q == 2'h2)
                out_data <= tail_q;
            else if (push && (cnt_q == 2'h0 || (pop && cnt_q == 2'h1)))
                out_data <= in_data;
            if (push && (cnt_q == 2'h2 || (cnt_q == 2'h1 && !pop)))
                tail_q <= in_data;
        end
    end

    no_overflow_a: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_q != 2'h3) else $error("pair buffer count out of range");
endmodule // oh_pair_buffer
`default_nettype wire

// *** design/sonet_oh_port.sv ***
// serial overhead link, channel status mirrors and protect selects
// assumes an apb master on pclk; all pin inputs are asynchronous
//
// Local design decisions: the APB register port and the placing of the registers.
`include "oh_regs.svh"
`default_nettype none

// Functional notes
// - with alignment bypassed, channel output strobes follow that channel's recovered clock
// - serial overhead ins and outs act only in serial overhead mode
// - each channel shifts its inserted overhead in on its own serial input
// - each channel shifts its extracted overhead out on its own serial output
// - receive overhead frame pulse lasts exactly one clock cycle at frame boundary
// - rx overhead clock enable status equals the clock and frame pulse bit
// - link clock active reads high while the link runs: serial mode, clock enable bit and tx clock enable all set
// - per-channel status mirrors that channel's receive data enable setting
// - per-channel status mirrors that channel's overhead enable setting
// - four parallel selects each switch both channels of one pair
// - eight serial selects each pick work or protect for one channel
module sonet_oh_port
    import oh_pkg::*;
(
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // overhead link pins
    input  wire logic        overhead_processor_clock,
    input  wire logic        tx_overhead_clock_enable,
    input  wire logic [7:0]  overhead_serial_in,
    output logic [7:0]       overhead_serial_out,
    output logic             rx_overhead_frame_pulse,
    output logic             rx_overhead_clock_enable_status,
    output logic             overhead_link_clock_active,
    output logic             overhead_in_ready,
    // core side overhead words
    input  wire logic [63:0] extract_data,
    output logic             extract_take,
    output logic [63:0]      insert_data,
    output logic             insert_valid,
    input  wire logic        insert_ready,
    // channel clocks and status
    input  wire logic [7:0]  recovered_channel_clock,
    output logic [7:0]       channel_byte_strobe,
    output logic [7:0]       rx_data_enable_status,
    output logic [7:0]       overhead_channel_enable_status,
    // protection selects
    input  wire logic        parallel_protect_select_pair0,
    input  wire logic        parallel_protect_select_pair1,
    input  wire logic        parallel_protect_select_pair2,
    input  wire logic        parallel_protect_select_pair3,
    input  wire logic [7:0]  serial_protect_select_channel,
    output logic [7:0]       parallel_protect_active,
    output logic [7:0]       serial_protect_active
);
    // configuration
    ctrl_t       ctrl_q;
    chen_t       chen_q;
    // pin synchronisers
    logic [29:0] pin_s1_q;
    logic [29:0] pin_s2_q;
    logic [29:0] pin_raw;
    logic        lk_s;
    logic        txen_s;
    logic [7:0]  ser_in_s;
    logic [3:0]  par_s;
    logic [7:0]  ser_sel_s;
    logic [7:0]  rec_s;
    logic        lk_prev_q;
    logic [7:0]  rec_prev_q;
    // link counters and shifters
    logic [2:0]  bit_cnt_q;
    logic [4:0]  byte_cnt_q;
    logic [3:0]  ref_cnt_q;
    logic [7:0][7:0] ins_sh_q;
    logic [7:0][7:0] ext_sh_q;
    logic [7:0][7:0] ins_next;
    logic [7:0][7:0] ext_next;
    logic [63:0] push_data;
    logic [7:0]  ser_out_d;
    logic [7:0]  strobe_d;
    logic        buf_in_ready;
    // decode wires
    logic        run;
    logic        lk_rise;
    logic        bit_step;
    logic        byte_done;
    logic        frame_done;
    logic        ref_tick;
    logic        setup_ph;
    logic        wr_acc;
    logic        sel_ctrl;
    logic        sel_chen;
    logic        sel_stat;
    logic        mapped;
    logic [31:0] rd_mux;
    prot_sel_t   prot;

    // pin synchronisation, two flops for every pin
    assign pin_raw = {overhead_processor_clock, tx_overhead_clock_enable,
                      overhead_serial_in,
                      parallel_protect_select_pair3, parallel_protect_select_pair2,
                      parallel_protect_select_pair1, parallel_protect_select_pair0,
                      serial_protect_select_channel, recovered_channel_clock};
    assign lk_s      = pin_s2_q[29];
    assign txen_s    = pin_s2_q[28];
    assign ser_in_s  = pin_s2_q[27:20];
    assign par_s     = pin_s2_q[19:16];
    assign ser_sel_s = pin_s2_q[15:8];
    assign rec_s     = pin_s2_q[7:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q   <= 30'h0;
            pin_s2_q   <= 30'h0;
            lk_prev_q  <= 1'b0;
            rec_prev_q <= 8'h00;
        end else begin
            pin_s1_q   <= pin_raw;
            pin_s2_q   <= pin_s1_q;
            lk_prev_q  <= lk_s;
            rec_prev_q <= rec_s;
        end
    end

    // apb decode
    assign setup_ph = psel & ~penable;
    assign wr_acc   = psel & penable & pready & pwrite;
    assign sel_ctrl = (paddr == `OH_CTRL_ADDR);
    assign sel_chen = (paddr == `OH_CHEN_ADDR);
    assign sel_stat = (paddr == `OH_STAT_ADDR);
    assign mapped   = sel_ctrl | sel_chen | sel_stat;
    assign prot     = '{serial: serial_protect_active, parallel: parallel_protect_active};
    assign rd_mux   = sel_ctrl ? {29'h0, ctrl_q} :
                      sel_chen ? {16'h0, chen_q} :
                      sel_stat ? {`OH_STAT_PAD, overhead_link_clock_active,
                                  ~buf_in_ready, prot} : 32'h0;

    // zero-wait answer in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~mapped;
            prdata  <= (setup_ph && !pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `OH_CTRL_RST;
            chen_q <= `OH_CHEN_RST;
        end else begin
            if (wr_acc && sel_ctrl)
                ctrl_q <= pwdata[2:0];
            if (wr_acc && sel_chen)
                chen_q <= pwdata[15:0];
        end
    end

    // link runs only in serial mode with clocks enabled
    assign run        = ctrl_q.serial_mode & ctrl_q.clk_fp_en & txen_s;
    assign lk_rise    = lk_s & ~lk_prev_q;
    assign bit_step   = run & lk_rise;
    assign byte_done  = bit_step & (bit_cnt_q == `OH_BIT_LAST);
    assign frame_done = byte_done & (byte_cnt_q == `OH_FRAME_LAST);
    assign ref_tick   = (ref_cnt_q == `OH_REF_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_q  <= 3'h0;
            byte_cnt_q <= 5'h00;
        end else if (!run) begin
            bit_cnt_q  <= 3'h0;
            byte_cnt_q <= 5'h00;
        end else if (bit_step) begin
            bit_cnt_q  <= bit_cnt_q + 3'h1;
            if (byte_done)
                byte_cnt_q <= frame_done ? 5'h00 : byte_cnt_q + 5'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ref_cnt_q <= 4'h0;
        else
            ref_cnt_q <= ref_cnt_q + 4'h1;
    end

    // per-channel shifters and output strobes
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_ch
            assign ins_next[g]  = {ins_sh_q[g][6:0], ser_in_s[g]};
            assign ext_next[g]  = byte_done ? extract_data[8*g +: 8]
                                            : {ext_sh_q[g][6:0], 1'b0};
            assign push_data[8*g +: 8] = chen_q.oh_en[g] ? ins_next[g] : 8'h00;
            assign ser_out_d[g] = run & chen_q.oh_en[g] & ext_next[g][7];
            assign strobe_d[g]  = chen_q.rx_en[g] &
                                  (ctrl_q.fifo_bypass ? (rec_s[g] & ~rec_prev_q[g])
                                                      : ref_tick);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ins_sh_q[g] <= 8'h00;
                    ext_sh_q[g] <= 8'h00;
                end else if (bit_step) begin
                    ins_sh_q[g] <= ins_next[g];
                    ext_sh_q[g] <= ext_next[g];
                end
            end
        end
    endgenerate

    // assembled words wait here until the core takes them
    oh_pair_buffer u_buf (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (byte_done),
        .in_ready  (buf_in_ready),
        .in_data   (push_data),
        .out_valid (insert_valid),
        .out_ready (insert_ready),
        .out_data  (insert_data)
    );

    // registered link and status outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overhead_serial_out             <= 8'h00;
            rx_overhead_frame_pulse         <= 1'b0;
            rx_overhead_clock_enable_status <= 1'b0;
            overhead_link_clock_active      <= 1'b0;
            overhead_in_ready               <= 1'b0;
            extract_take                    <= 1'b0;
            channel_byte_strobe             <= 8'h00;
        end else begin
            if (bit_step || !run)
                overhead_serial_out <= ser_out_d;
            rx_overhead_frame_pulse         <= frame_done;
            rx_overhead_clock_enable_status <= ctrl_q.clk_fp_en;
            overhead_link_clock_active      <= run;
            overhead_in_ready               <= buf_in_ready;
            extract_take                    <= byte_done;
            channel_byte_strobe             <= strobe_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_enable_status          <= 8'h00;
            overhead_channel_enable_status <= 8'h00;
            parallel_protect_active        <= 8'h00;
            serial_protect_active          <= 8'h00;
        end else begin
            rx_data_enable_status          <= chen_q.rx_en;
            overhead_channel_enable_status <= chen_q.oh_en;
            parallel_protect_active        <= pair_expand(par_s);
            serial_protect_active          <= ser_sel_s;
        end
    end

    // checks
    frame_pulse_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        rx_overhead_frame_pulse |=> !rx_overhead_frame_pulse)
        else $error("frame pulse longer than one cycle");

    clock_status_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 rx_overhead_clock_enable_status == $past(ctrl_q.clk_fp_en))
        else $error("clock enable status differs from control bit");

    link_active_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(run) |=> overhead_link_clock_active)
        else $error("link active missing while link runs");

    rx_enable_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(chen_q.rx_en) |=> rx_data_enable_status == $past(chen_q.rx_en))
        else $error("receive enable status not mirrored");

    oh_enable_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 overhead_channel_enable_status == $past(chen_q.oh_en))
        else $error("overhead enable status not mirrored");

    pair_select_both_a: assert property (@(posedge pclk) disable iff (!presetn)
        parallel_protect_active == pair_expand(parallel_protect_active[6:0] == 7'h0 ?
        {3'h0, parallel_protect_active[0]} :
        {parallel_protect_active[6], parallel_protect_active[4],
         parallel_protect_active[2], parallel_protect_active[0]}))
        else $error("pair channels selected apart");

    serial_select_ch_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 serial_protect_active == $past(ser_sel_s))
        else $error("serial select not per channel");

    mode_gate_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_q.serial_mode ##1 !ctrl_q.serial_mode |-> overhead_serial_out == 8'h00)
        else $error("serial output active outside serial mode");

    shift_in_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        bit_step |=> ins_sh_q[0][0] == $past(ser_in_s[0]))
        else $error("inserted bit not shifted in");

    bypass_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q.fifo_bypass && chen_q.rx_en[0] && rec_s[0] && !rec_prev_q[0]
        |=> channel_byte_strobe[0])
        else $error("bypass strobe not on recovered clock edge");

    frame_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
        rx_overhead_frame_pulse);
    buffer_full_c: cover property (@(posedge pclk) disable iff (!presetn)
        !overhead_in_ready && run);
    bypass_used_c: cover property (@(posedge pclk) disable iff (!presetn)
        ctrl_q.fifo_bypass && |channel_byte_strobe);
endmodule // sonet_oh_port
`default_nettype wire

// *** bench/oh_far_model.sv ***
// far-side fpga logic: overhead clock, tx enable and serial insert bits
// assumes the bench raises run at a pclk edge; bytes always go out whole
`default_nettype none
module oh_far_model (
    // control from bench
    input  wire logic        run,
    input  wire logic [63:0] next_bytes,
    // link pins
    output logic             link_clk,
    output logic             tx_en,
    output logic [7:0]       ser_in,
    // bookkeeping
    output logic [63:0]      sent_bytes,
    output int               n_bytes
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        {link_clk, tx_en, ser_in, sent_bytes} = '0;
        n_bytes = 0;
    end

    // link clock stands low outside runs, phase off the pclk edges
    always begin
        wait (run);
        #1;
        tx_en = 1'b1;
        while (run) begin
            sent_bytes = next_bytes;
            n_bytes++;
            for (int b = 7; b >= 0; b--) begin
                for (int g = 0; g < 8; g++) ser_in[g] = sent_bytes[8*g+b];
                #32 link_clk = 1'b1;
                #32 link_clk = 1'b0;
            end
        end
        tx_en  = 1'b0;
        ser_in = ~ser_in;
    end
endmodule // oh_far_model
`default_nettype wire

// *** bench/test_sonet_oh_port.sv ***
// self-checking bench for the overhead port: apb, link, selects, strobes
// assumes oh_far_model on the link pins and pclk at 250 MHz
`include "oh_regs.svh"
`default_nettype none
module test_sonet_oh_port;
    timeunit 1ns;
    timeprecision 100ps;

    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, insert_ready, run;
    logic        push_en, ser_chk, link_clk, tx_en, fp, rx_ck_st, link_act, ins_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  ser_in, ser_out, rcv_clk, strobe, rx_st, oh_st, sprot, pp_act, sp_act;
    logic [3:0]  pprot;
    logic [63:0] ext_data, ins_data, tx_next, sh, mask;
    logic        in_rdy, take;
    int          n_bytes, fails, n_compared, nbit, n_fp, fp_len, n_take;
    int          n_strobe [8];
    logic [32:0] rd_q [$];
    logic [63:0] ins_q [$];

    always #2 pclk = ~pclk;

    sonet_oh_port dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .overhead_processor_clock(link_clk), .tx_overhead_clock_enable(tx_en),
        .overhead_serial_in(ser_in), .overhead_serial_out(ser_out),
        .rx_overhead_frame_pulse(fp), .rx_overhead_clock_enable_status(rx_ck_st),
        .overhead_link_clock_active(link_act), .overhead_in_ready(in_rdy),
        .extract_data(ext_data), .extract_take(take), .insert_data(ins_data),
        .insert_valid(ins_valid), .insert_ready(insert_ready),
        .recovered_channel_clock(rcv_clk), .channel_byte_strobe(strobe),
        .rx_data_enable_status(rx_st), .overhead_channel_enable_status(oh_st),
        .parallel_protect_select_pair0(pprot[0]), .parallel_protect_select_pair1(pprot[1]),
        .parallel_protect_select_pair2(pprot[2]), .parallel_protect_select_pair3(pprot[3]),
        .serial_protect_select_channel(sprot), .parallel_protect_active(pp_act),
        .serial_protect_active(sp_act)
    );

    oh_far_model far (
        .run(run), .next_bytes(tx_next), .link_clk(link_clk), .tx_en(tx_en),
        .ser_in(ser_in), .sent_bytes(), .n_bytes(n_bytes)
    );

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fails++;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic err, input logic [31:0] exp);
        rd_q.push_back({err, exp});
        apb(1'b0, a, 32'h0);
    endtask

    // output monitor: apb reads, insert words, frame pulses, strobes
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0) begin
            check("apb read", 64'({pslverr, prdata}), 64'(rd_q.pop_front()));
        end
        if (ins_valid === 1'b1 && insert_ready) begin
            if (ins_q.size() == 0) check("stray insert word", 64'h1, 64'h0);
            else check("insert word", ins_data, ins_q.pop_front());
        end
        if (fp === 1'b1) fp_len++;
        else if (fp_len != 0) begin
            check("frame pulse width", 64'(fp_len), 64'h1);
            n_fp++;
            fp_len = 0;
        end
        for (int g = 0; g < 8; g++) n_strobe[g] += int'(strobe[g] === 1'b1);
        n_take += int'(take === 1'b1);
    end

    always @(posedge pclk) insert_ready <= 1'($urandom() % 2);

    always @(n_bytes) begin
        if (push_en) ins_q.push_back(tx_next & mask);
        tx_next = {$urandom(), $urandom()};
    end

    // serial out sampled mid link period, first byte of a run skipped
    always @(negedge link_clk) begin
        if (ser_chk) begin
            for (int g = 0; g < 8; g++) sh[8*g +: 8] = {sh[8*g +: 7], ser_out[g]};
            nbit++;
            if (nbit % 8 == 7 && nbit > 8) check("serial out byte", sh, ext_data & mask);
        end else if (run) check("serial out idle", 64'(ser_out), 64'h0);
    end

    initial begin
        #60000;
        fails++;
        wrap_up();
    end

    initial begin
        logic [15:0] chen;
        logic [7:0]  sp;
        logic [7:0]  pe;
        logic [3:0]  pp;
        void'($urandom(32'hAEC2));
        tx_next = {$urandom(), $urandom()};
        {presetn, psel, penable, pwrite, run, push_en, ser_chk, insert_ready} = '0;
        {paddr, pwdata, ext_data, sh, mask, rcv_clk, sprot, pprot} = '0;
        {fails, n_compared, nbit, n_fp, fp_len, n_take} = '0;
        n_strobe = '{default: 0};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`OH_CTRL_ADDR, 1'b0, 32'h0);
        rd(`OH_CHEN_ADDR, 1'b0, 32'h0);
        rd(12'h00C, 1'b1, 32'h0);
        chen = 16'($urandom()) & 16'hF5FF | 16'h8100;
        for (int g = 0; g < 8; g++) mask[8*g +: 8] = {8{chen[8+g]}};
        apb(1'b1, `OH_CHEN_ADDR, {16'h0, chen});
        rd(`OH_CHEN_ADDR, 1'b0, {16'h0, chen});
        check("rx enable status", 64'(rx_st), 64'(chen[7:0]));
        check("oh enable status", 64'(oh_st), 64'(chen[15:8]));
        repeat (3) begin
            pp = 4'($urandom());
            sp = 8'($urandom());
            pe = {pp[3], pp[3], pp[2], pp[2], pp[1], pp[1], pp[0], pp[0]};
            pprot <= pp;
            sprot <= sp;
            repeat (8) @(posedge pclk);
            check("parallel select", 64'(pp_act), 64'(pe));
            check("serial select", 64'(sp_act), 64'(sp));
            rd(`OH_STAT_ADDR, 1'b0, {16'h0, sp, pe});
        end
        apb(1'b1, `OH_CHEN_ADDR, {16'h0, chen[15:8], 8'hFF});
        apb(1'b1, `OH_CTRL_ADDR, 32'h4);
        repeat (2) @(posedge pclk);
        check("rx clock enable status", 64'(rx_ck_st), 64'h0);
        n_strobe = '{default: 0};
        repeat (32) begin
            repeat (4) @(posedge pclk);
            rcv_clk[5] <= ~rcv_clk[5];
        end
        repeat (8) @(posedge pclk);
        check("idle channel strobes", 64'(n_strobe.sum() - n_strobe[5]), 64'h0);
        check("channel clock strobes", 64'(n_strobe[5] > 0), 64'h1);
        apb(1'b1, `OH_CTRL_ADDR, 32'h3);
        repeat (2) @(posedge pclk);
        check("rx clock enable status", 64'(rx_ck_st), 64'h1);
        ext_data <= {$urandom(), $urandom()};
        push_en = 1'b1;
        ser_chk = 1'b1;
        run <= 1'b1;
        while (n_bytes < 3) @(posedge pclk);
        check("link clock active", 64'(link_act), 64'h1);
        while (n_bytes < 26) @(posedge pclk);
        run <= 1'b0;
        wait (tx_en === 1'b0);
        repeat (40) @(posedge pclk);
        check("words left", 64'(ins_q.size()), 64'h0);
        check("insert ready idle", 64'(in_rdy), 64'h1);
        check("extract takes", 64'(n_take), 64'h1A);
        check("link clock stopped", 64'(link_act), 64'h0);
        {push_en, ser_chk} = 2'h0;
        apb(1'b1, `OH_CTRL_ADDR, 32'h2);
        check("rx clock enable status", 64'(rx_ck_st), 64'h1);
        run <= 1'b1;
        while (n_bytes < 28) @(posedge pclk);
        check("link clock off mode", 64'(link_act), 64'h0);
        run <= 1'b0;
        wait (tx_en === 1'b0);
        repeat (40) @(posedge pclk);
        check("frame pulses", 64'(n_fp), 64'h1);
        check("extract takes off mode", 64'(n_take), 64'h1A);
        wrap_up();
    end
endmodule // test_sonet_oh_port
`default_nettype wire
